// *** logic/logout_pkg.sv ***
// Constants, types and word map of the logout image formatter
package logout_pkg;

  // ----------------------------------------------------------------
  // Image word addresses (byte addresses, one fullword each)
  // ----------------------------------------------------------------
  localparam int          AW         = 12;
  localparam logic [11:0] A_SAR      = 12'h084;
  localparam logic [11:0] A_IAR      = 12'h088;
  localparam logic [11:0] A_MW1      = 12'h08c;
  localparam logic [11:0] A_MW2      = 12'h090;
  localparam logic [11:0] A_MW3      = 12'h094;
  localparam logic [11:0] A_MW4      = 12'h098;
  localparam logic [11:0] A_OPST     = 12'h09c;
  localparam logic [11:0] A_CHK      = 12'h0a0;
  localparam logic [11:0] A_OPCOPY   = 12'h0a8;
  localparam logic [11:0] A_MODE     = 12'h0ac;
  localparam logic [11:0] A_LSTORE   = 12'h0b0;
  localparam logic [11:0] A_LCS      = 12'h0b4;
  localparam logic [11:0] A_REGS     = 12'h0b8;
  localparam logic [11:0] A_REGS_END = 12'h0dc;
  localparam logic [11:0] A_IOINST   = 12'h0e0;
  localparam logic [11:0] A_CHRTNE   = 12'h0e4;
  localparam logic [11:0] A_BUFST    = 12'h0e8;
  localparam logic [11:0] A_BUFDAT   = 12'h0ec;
  localparam logic [11:0] A_IFACE    = 12'h0f0;
  localparam logic [11:0] A_MPXCTL   = 12'h0f4;
  localparam logic [11:0] A_SELB     = 12'h0f8;
  localparam logic [11:0] A_SELBP    = 12'h0fc;
  localparam logic [11:0] A_SELCP    = 12'h100;
  localparam logic [11:0] A_SELC     = 12'h104;
  localparam logic [11:0] A_SELCHK   = 12'h108;
  localparam logic [11:0] A_GRP3     = 12'h10c;
  localparam logic [11:0] A_GRP4     = 12'h110;
  localparam logic [11:0] A_POS      = 12'h114;
  localparam logic [11:0] A_GPREG    = 12'h118;
  localparam logic [11:0] A_SELCTL   = 12'h11c;
  localparam logic [11:0] A_SELSTOP  = 12'h120;
  localparam logic [11:0] A_RSV      = 12'h124;
  localparam logic [11:0] A_CHAN_LOW = 12'h088;

  // ----------------------------------------------------------------
  // Field positions: first bit, bit 0 being the word's high end
  // ----------------------------------------------------------------
  localparam int F_W0     = 0;
  localparam int F_AEXT   = 12;
  localparam int F_ACTL   = 16;
  localparam int F_GATE   = 4;
  localparam int F_MDEST  = 9;
  localparam int F_MOVFN  = 26;
  localparam int F_EMIT   = 1;
  localparam int F_STATHI = 28;
  localparam int F_STATLO = 24;
  localparam int F_ROSADR = 6;
  localparam int F_IRQREG = 18;
  localparam int F_INTST  = 4;
  localparam int F_LEN    = 20;
  localparam int F_FOLD   = 24;
  localparam int F_IOFLAG = 12;
  localparam int F_SBC    = 14;
  localparam int F_MWSEL  = 19;
  localparam int F_RREQ   = 4;
  localparam int F_PRI    = 9;
  localparam int F_CTLT   = 12;
  localparam int F_PAR4   = 28;
  localparam int F_CSTEP  = 8;
  localparam int F_MPXR   = 18;
  localparam int F_POSR   = 11;
  localparam int F_FLAGS  = 9;
  localparam int F_GPREST = 14;
  localparam int F_RSVMPX = 16;

  // ----------------------------------------------------------------
  // Software port: offsets and bits
  // ----------------------------------------------------------------
  localparam logic [3:0] R_CTRL   = 4'h0;
  localparam logic [3:0] R_STATUS = 4'h4;
  localparam int         C_START  = 0;
  localparam int         C_CHAN   = 1;
  localparam int         C_CLRDN  = 2;
  localparam int         S_BUSY   = 0;
  localparam int         S_CHAN   = 1;
  localparam int         S_DONE   = 2;

  typedef enum logic {ST_IDLE, ST_RUN} run_st_t;

endpackage

// *** logic/logout_byte_parity.sv ***
// Odd parity generator, one bit per byte of a storage word
module logout_byte_parity
  import logout_pkg::*;
#(
  parameter int BYTES = 4
)(
  // Word to be sent to storage
  input  wire logic [8*BYTES-1:0] i_word,
  // Parity, bit BYTES-1 covers the high byte
  output      logic [BYTES-1:0]   o_par
);

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  if (BYTES < 1)
  begin : g_bad
    $error("logout_byte_parity: BYTES must be at least 1");
  end

  // ----------------------------------------------------------------
  // One XOR tree per byte
  // ----------------------------------------------------------------
  for (genvar b = 0; b < BYTES; b++)
  begin : g_byte
    // Odd parity: the nine bits of a byte always hold an odd count
    assign o_par[b] = ~(^i_word[8*b +: 8]);
  end

endmodule

// *** logic/logout_image_layout.sv ***
// Logout image formatter: packs machine state into storage words
//
// Behaviour
// - Word 08C: address extension, address control
// - Word 090: adder gating, mover destination
// - Word 094: group parity, emit field
// - Stat-setting field split across two words
// - Op stats word written again later
// - Mode word: timer, console interrupts bits 4-5
// - H register full word plus fold
// - Same pair for M, R, L, storage data
// - I/O instruction status flags bits 12-16
// - Routine word: byte control, microword bits
// - Mux channel triggers, priority, control triggers
// - B register word then parity word
// - C register parity word then data
// - Channel checks word, low or high address
// - Position register and cycle step bits
// - Common channel detect in bits 28-31
// - Five channel flags in bits 9-13
// - Last word reserved, two halves
// - Length counters in local store word
// - Group-4 parity word, rest unused
// - Odd parity generated per stored byte
// - Parity-carrying register takes two words
//
// Decided for this implementation: the strobed register port and the register addresses.
module logout_image_layout
  import logout_pkg::*;
(
  // Clock and reset
  input  wire logic         i_clk_sys,
  input  wire logic         i_rst,
  // Software port
  input  wire logic [3:0]   i_reg_addr,
  input  wire logic [31:0]  i_reg_wdata,
  input  wire logic         i_reg_wr,
  input  wire logic         i_reg_rd,
  output      logic [31:0]  o_reg_rdata,
  // Storage write path
  output      logic         o_sto_we,
  output      logic [11:0]  o_sto_addr,
  output      logic [31:0]  o_sto_data,
  output      logic [3:0]   o_sto_par,
  // Processor state
  input  wire logic [31:0]  i_storage_address_reg,
  input  wire logic [2:0]   i_sar_par,
  input  wire logic [3:0]   i_byte_stats,
  input  wire logic [31:0]  i_instruction_address_reg,
  input  wire logic [2:0]   i_iar_par,
  input  wire logic [0:95]  i_microword_data_reg,
  input  wire logic [0:2]   i_mw_grp_par,
  input  wire logic [5:0]   i_mover_fn,
  input  wire logic [11:0]  i_prev_ros_addr,
  input  wire logic [11:0]  i_cur_ros_addr,
  input  wire logic [1:0]   i_op_stats,
  input  wire logic [13:0]  i_irq_psw,
  input  wire logic [26:0]  i_check_bits,
  input  wire logic [3:0]   i_io_mode,
  input  wire logic         i_timer_irq,
  input  wire logic         i_console_irq,
  input  wire logic [24:0]  i_mode_rest,
  input  wire logic [18:0]  i_ls_ctl,
  input  wire logic [5:0]   i_len_ctr1,
  input  wire logic [5:0]   i_len_ctr2,
  input  wire logic [8:0]   i_large_core_option,
  input  wire logic [31:0]  i_h,
  input  wire logic [31:0]  i_m,
  input  wire logic [31:0]  i_r,
  input  wire logic [31:0]  i_l,
  input  wire logic [31:0]  i_storage_data_reg,
  // Channel state
  input  wire logic [11:0]  i_io_inst,
  input  wire logic [4:0]   i_io_flags,
  input  wire logic [13:0]  i_rtne_ctl,
  input  wire logic [3:0]   i_sbc_reg,
  input  wire logic         i_first_cyc_chk,
  input  wire logic [23:0]  i_buf_status,
  input  wire logic [18:0]  i_buf_data,
  input  wire logic [21:0]  i_iface_lines,
  input  wire logic [3:0]   i_ctl_emit,
  input  wire logic [4:0]   i_rtne_req,
  input  wire logic [2:0]   i_priority,
  input  wire logic [5:0]   i_ctl_trigs,
  input  wire logic [5:0]   i_mpx_rest,
  input  wire logic [31:0]  i_sel_b,
  input  wire logic [3:0]   i_sel_b_par,
  input  wire logic [31:0]  i_sel_c,
  input  wire logic [3:0]   i_sel_c_par,
  input  wire logic [23:0]  i_sel_status,
  input  wire logic [7:0]   i_sel_checks,
  input  wire logic [3:0]   i_grp3_par,
  input  wire logic [3:0]   i_grp4_par,
  input  wire logic [7:0]   i_position_reg,
  input  wire logic [2:0]   i_cyc_step,
  input  wire logic [15:0]  i_pos_rest,
  input  wire logic [3:0]   i_cc_detect,
  input  wire logic [6:0]   i_gp_reg,
  input  wire logic [4:0]   i_chan_flags,
  input  wire logic [17:0]  i_gp_rest,
  input  wire logic [31:0]  i_sel_ctl,
  input  wire logic [3:0]   i_sel_stop,
  input  wire logic [15:0]  i_rsv_sel,
  input  wire logic [15:0]  i_rsv_mpx
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    run_st_t     st;     // Idle or emitting words
    logic        chan;   // Channel-only image in progress
    logic        done;   // Sticky end-of-image flag
    logic [5:0]  idx;    // Word number within the image
    logic        we;     // Storage write strobe
    logic [11:0] addr;   // Storage word address
    logic [31:0] data;   // Storage word data
    logic [3:0]  par;    // Storage byte parity
    logic [31:0] rdata;  // Software read data
  } state_t;

  state_t q, d;
  logic [11:0] fa;       // Full-image address of the current word
  logic [31:0] word;     // Formatted word
  logic [3:0]  par;      // Its generated parity
  logic        last;     // Current word ends the image
  logic [31:0] rsel;     // Selected working register for pairs

  // Places v so that its top bit lands on bit number 'first'
  function automatic logic [31:0] put(input logic [31:0] w,
                                      input int first,
                                      input int width,
                                      input logic [31:0] v);
    logic [31:0] m;
    m   = (32'hffffffff >> (32 - width)) << (32 - first - width);
    put = w | ((v << (32 - first - width)) & m);
  endfunction

  // Op stats, current control address and interrupt bits
  function automatic logic [31:0] op_word();
    logic [31:0] w;
    w = put(32'h0, F_W0, 2, 32'(i_op_stats));
    w = put(w, F_ROSADR, 12, 32'(i_cur_ros_addr));
    op_word = put(w, F_IRQREG, 14, 32'(i_irq_psw));
  endfunction

  // ----------------------------------------------------------------
  // Address walk: full image from 084, channel-only from B register
  // ----------------------------------------------------------------
  always_comb
  begin
    fa   = (q.chan ? A_SELB : A_SAR) + {4'h0, q.idx, 2'b00};
    last = (fa == A_RSV);
  end

  // ----------------------------------------------------------------
  // Working register pairs: data word, then fold word
  // ----------------------------------------------------------------
  always_comb
  begin
    unique case (fa[5:3] - A_REGS[5:3])
      3'd0:    rsel = i_h;
      3'd1:    rsel = i_m;
      3'd2:    rsel = i_r;
      3'd3:    rsel = i_l;
      default: rsel = i_storage_data_reg;
    endcase
  end

  // ----------------------------------------------------------------
  // Word formatter; every position not filled stays zero
  // ----------------------------------------------------------------
  always_comb
  begin
    word = 32'h0;
    if (fa >= A_REGS && fa <= A_REGS_END)
    begin
      // Even word holds 32 data bits, odd word bits 28-31 at 24-27
      if (fa[2])
        word = put(32'h0, F_FOLD, 4, 32'(rsel[3:0]));
      else
        word = rsel;
    end
    else
    begin
      unique case (fa)
        A_SAR:
          word = {i_sar_par[2], i_storage_address_reg[23:16],
                  i_sar_par[1], i_storage_address_reg[15:8],
                  i_sar_par[0], i_storage_address_reg[7:0],
                  1'b0, i_byte_stats};
        A_IAR:
          word = {i_iar_par[2], i_instruction_address_reg[23:16],
                  i_iar_par[1], i_instruction_address_reg[15:8],
                  i_iar_par[0], i_instruction_address_reg[7:0],
                  5'h00};
        A_MW1:
        begin
          word = put(32'h0, F_W0, 1, 32'(i_mw_grp_par[0]));
          word = put(word, 1, 11, 32'(i_microword_data_reg[1:11]));
          word = put(word, F_AEXT, 4,
                     32'(i_microword_data_reg[12:15]));
          word = put(word, F_ACTL, 3,
                     32'(i_microword_data_reg[16:18]));
          word = put(word, 20, 5, 32'(i_microword_data_reg[19:23]));
          word = put(word, 26, 6, 32'(i_microword_data_reg[25:30]));
        end
        A_MW2:
        begin
          word = put(32'h0, F_W0, 1, 32'(i_mw_grp_par[1]));
          word = put(word, 1, 3, 32'(i_microword_data_reg[32:34]));
          word = put(word, F_GATE, 5,
                     32'(i_microword_data_reg[35:39]));
          word = put(word, F_MDEST, 4,
                     32'(i_microword_data_reg[40:43]));
          word = put(word, 13, 12, 32'(i_microword_data_reg[44:55]));
          word = put(word, F_MOVFN, 6, 32'(i_mover_fn));
        end
        A_MW3:
        begin
          word = put(32'h0, F_W0, 1, 32'(i_mw_grp_par[2]));
          word = put(word, F_EMIT, 4,
                     32'(i_microword_data_reg[57:60]));
          word = put(word, 5, 22, 32'(i_microword_data_reg[61:82]));
          word = put(word, F_STATHI, 4,
                     32'(i_microword_data_reg[84:87]));
        end
        A_MW4:
        begin
          word = put(32'h0, F_ROSADR, 12, 32'(i_prev_ros_addr));
          word = put(word, F_STATLO, 2,
                     32'(i_microword_data_reg[88:89]));
        end
        A_OPST, A_OPCOPY:
          word = op_word();
        A_CHK:
          word = put(32'h0, F_W0, 27, 32'(i_check_bits));
        A_MODE:
        begin
          word = put(32'h0, F_W0, 4, 32'(i_io_mode));
          word = put(word, F_INTST, 2,
                     32'({i_timer_irq, i_console_irq}));
          word = put(word, 6, 25, 32'(i_mode_rest));
        end
        A_LSTORE:
        begin
          word = put(32'h0, F_W0, 19, 32'(i_ls_ctl));
          word = put(word, F_LEN, 12,
                     32'({i_len_ctr1, i_len_ctr2}));
        end
        A_LCS:
          word = put(32'h0, F_W0, 9,
                     32'(i_large_core_option & 9'h1ef));
        A_IOINST:
        begin
          word = put(32'h0, F_W0, 12, 32'(i_io_inst));
          word = put(word, F_IOFLAG, 5, 32'(i_io_flags));
        end
        A_CHRTNE:
        begin
          word = put(32'h0, F_W0, 14, 32'(i_rtne_ctl));
          word = put(word, F_SBC, 4, 32'(i_sbc_reg));
          word = put(word, F_MWSEL, 5,
                     32'({i_microword_data_reg[33], i_microword_data_reg[34],
                          i_microword_data_reg[47], i_microword_data_reg[48],
                          i_first_cyc_chk}));
        end
        A_BUFST:
          word = put(32'h0, F_W0, 24, 32'(i_buf_status));
        A_BUFDAT:
          word = put(32'h0, F_W0, 19, 32'(i_buf_data));
        A_IFACE:
          word = put(32'h0, F_W0, 22, 32'(i_iface_lines));
        A_MPXCTL:
        begin
          word = put(32'h0, F_W0, 4, 32'(i_ctl_emit));
          word = put(word, F_RREQ, 5, 32'(i_rtne_req));
          word = put(word, F_PRI, 3, 32'(i_priority));
          word = put(word, F_CTLT, 6, 32'(i_ctl_trigs));
          word = put(word, F_MPXR, 6, 32'(i_mpx_rest));
        end
        A_SELB:
          word = i_sel_b;
        A_SELBP:
          word = put(32'h0, F_PAR4, 4, 32'(i_sel_b_par));
        A_SELCP:
          word = put(32'h0, F_PAR4, 4, 32'(i_sel_c_par));
        A_SELC:
          word = i_sel_c;
        A_SELCHK:
        begin
          word = put(32'h0, F_W0, 24, 32'(i_sel_status));
          word = put(word, F_STATLO, 8, 32'(i_sel_checks));
        end
        A_GRP3:
          word = put(32'h0, F_PAR4, 4, 32'(i_grp3_par));
        A_GRP4:
          word = put(32'h0, F_PAR4, 4, 32'(i_grp4_par));
        A_POS:
        begin
          word = put(32'h0, F_W0, 8, 32'(i_position_reg));
          word = put(word, F_CSTEP, 3, 32'(i_cyc_step));
          word = put(word, F_POSR, 16, 32'(i_pos_rest));
          word = put(word, F_PAR4, 4, 32'(i_cc_detect));
        end
        A_GPREG:
        begin
          word = put(32'h0, F_W0, 7, 32'(i_gp_reg));
          word = put(word, F_FLAGS, 5, 32'(i_chan_flags));
          word = put(word, F_GPREST, 18, 32'(i_gp_rest));
        end
        A_SELCTL:
          word = i_sel_ctl;
        A_SELSTOP:
          word = put(32'h0, F_PAR4, 4, 32'(i_sel_stop));
        A_RSV:
          word = put(32'h0, F_RSVMPX, 16,
                     32'(i_rsv_mpx)) | {i_rsv_sel, 16'h0};
        // Spare word and anything unmapped go out as zero
        default:
          word = 32'h0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Byte parity for the outgoing word
  // ----------------------------------------------------------------
  logout_byte_parity #(
    .BYTES (4)
  ) u_par (
    .i_word (word),
    .o_par  (par)
  );

  // ----------------------------------------------------------------
  // Next state: software port, sequencer, storage outputs
  // ----------------------------------------------------------------
  always_comb
  begin
    d       = q;
    d.we    = 1'b0;
    d.rdata = 32'h0;
    // Read data stand only in the cycle after the strobe
    if (i_reg_rd)
    begin
      if (i_reg_addr == R_STATUS)
        d.rdata = {18'h0, q.idx, 5'h00, q.done, q.chan,
                   q.st == ST_RUN};
      else if (i_reg_addr == R_CTRL)
        d.rdata = {30'h0, q.chan, 1'b0};
    end
    // Clearing done loses to a completion in the same cycle
    if (i_reg_wr && i_reg_addr == R_CTRL && i_reg_wdata[C_CLRDN])
      d.done = 1'b0;
    unique case (q.st)
      ST_IDLE:
      begin
        // A start while busy is ignored; mode latched at start
        if (i_reg_wr && i_reg_addr == R_CTRL && i_reg_wdata[C_START])
        begin
          d.st   = ST_RUN;
          d.chan = i_reg_wdata[C_CHAN];
          d.idx  = 6'h00;
        end
      end
      ST_RUN:
      begin
        // One storage write per cycle, ascending fullwords
        d.we   = 1'b1;
        d.addr = q.chan ? A_CHAN_LOW + {4'h0, q.idx, 2'b00} : fa;
        d.data = word;
        d.par  = par;
        d.idx  = q.idx + 6'h01;
        if (last)
        begin
          d.st   = ST_IDLE;
          d.done = 1'b1;
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
      q <= '0;
    else
      q <= d;
  end

  assign o_sto_we    = q.we;
  assign o_sto_addr  = q.addr;
  assign o_sto_data  = q.data;
  assign o_sto_par   = q.par;
  assign o_reg_rdata = q.rdata;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_rst);

  addr_ascends_a: assert property (
    o_sto_we && $past(o_sto_we) |-> o_sto_addr == $past(o_sto_addr) + 12'h004)
    else $error("storage address did not step by one word");

  start_writes_a: assert property (
    q.st == ST_IDLE && i_reg_wr && i_reg_addr == R_CTRL && i_reg_wdata[C_START]
    |-> ##1 !o_sto_we ##1 o_sto_we [*8])
    else $error("start did not begin a write burst");

  byte_parity_a: assert property (
    o_sto_we |-> ^{o_sto_data[31:24], o_sto_par[3]} && ^{o_sto_data[23:16], o_sto_par[2]}
    && ^{o_sto_data[15:8], o_sto_par[1]} && ^{o_sto_data[7:0], o_sto_par[0]})
    else $error("stored byte parity not odd");

  h_fold_a: assert property (
    o_sto_we && !q.chan && o_sto_addr == A_REGS + 12'h004
    |-> o_sto_data == {24'h0, i_h[3:0], 4'h0} && $past(o_sto_data) == i_h)
    else $error("H register pair wrong");

  op_copy_a: assert property (
    o_sto_we && !q.chan && o_sto_addr == A_OPCOPY |-> o_sto_data == $past(o_sto_data, 3))
    else $error("op stats copy differs");

  emit_field_a: assert property (
    o_sto_we && !q.chan && o_sto_addr == A_MW3
    |-> o_sto_data[30:27] == i_microword_data_reg[57:60])
    else $error("emit field misplaced");

  int_stats_a: assert property (
    o_sto_we && !q.chan && o_sto_addr == A_MODE
    |-> o_sto_data[27:26] == {i_timer_irq, i_console_irq})
    else $error("interrupt stats misplaced");

  chan_checks_a: assert property (
    o_sto_we && q.chan && o_sto_addr == A_CHAN_LOW + 12'h010
    |-> o_sto_data[7:0] == i_sel_checks)
    else $error("channel checks misplaced in channel-only image");

  // The reserved word closes both images, so done and idle must come with it
  last_word_a: assert property (
    o_sto_we && o_sto_addr == (q.chan ? A_CHAN_LOW + (A_RSV - A_SELB) : A_RSV)
    |-> o_sto_data == {i_rsv_sel, i_rsv_mpx} && q.done && q.st == ST_IDLE)
    else $error("reserved word wrong or image did not end on it");

  full_done_c: cover property (q.st == ST_RUN && !q.chan && last);
  chan_done_c: cover property (q.st == ST_RUN && q.chan && last);
  busy_start_c: cover property (q.st == ST_RUN && i_reg_wr && i_reg_wdata[C_START]);

endmodule

// *** testbench/logout_store.sv ***
// Main storage model that takes the logout words
module logout_store (
  input wire logic        i_clk_sys,
  input wire logic        i_we,
  input wire logic [11:0] i_addr,
  input wire logic [35:0] i_word
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [35:0] mem [0:1023]; // Parity above data, one entry a fullword
  logic [11:0] log_a [0:63]; // Addresses in order of arrival
  int          n = 0;        // Words taken so far
  // Every strobe is taken at once; storage never holds the formatter up
  always @(posedge i_clk_sys)
    if (i_we)
    begin
      mem[i_addr[11:2]] <= i_word;
      log_a[n[5:0]] <= i_addr;
      n <= n + 1;
    end
endmodule

// *** testbench/tb.sv ***
// Self-checking bench for the logout image formatter
module tb
  import logout_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // Clock, reset and software port
  logic i_clk_sys = 0, i_rst = 1, i_reg_wr = 0, i_reg_rd = 0, o_sto_we;
  logic [3:0] i_reg_addr = 0, o_sto_par;
  logic [31:0] i_reg_wdata = 0, o_reg_rdata, o_sto_data, d;
  logic [11:0] o_sto_addr;
  // State snapshot: distinct values where a field is judged, ones elsewhere
  logic [0:95] i_microword_data_reg = 96'h0123_4567_89ab_cdef_0f1e_2d3c;
  logic [31:0] i_storage_address_reg = '1, i_instruction_address_reg = '1, i_sel_ctl = '1;
  logic [31:0] i_h = 32'h1234_5679, i_m = 32'hfedc_ba92, i_r = 32'h0f0f_0f05;
  logic [31:0] i_l = 32'h8000_000c, i_storage_data_reg = 32'h7777_7771;
  logic [31:0] i_sel_b = 32'hcafe_f00d, i_sel_c = 32'h5a5a_0ff0;
  logic [3:0] i_byte_stats = '1, i_io_mode = '1, i_sbc_reg = 4'h5, i_ctl_emit = '1;
  logic [3:0] i_sel_b_par = 4'h6, i_sel_c_par = 4'h9, i_grp3_par = '1, i_grp4_par = 4'h3;
  logic [3:0] i_cc_detect = 4'ha, i_sel_stop = '1;
  logic [2:0] i_sar_par = '1, i_iar_par = '1, i_mw_grp_par = '1, i_priority = 3'h5;
  logic [2:0] i_cyc_step = 3'h2;
  logic i_timer_irq = 1, i_console_irq = 0, i_first_cyc_chk = 1;
  logic [5:0] i_mover_fn = '1, i_len_ctr1 = 6'h25, i_len_ctr2 = '1, i_ctl_trigs = 6'h2d;
  logic [5:0] i_mpx_rest = '1;
  logic [11:0] i_prev_ros_addr = '1, i_cur_ros_addr = 12'h5c3, i_io_inst = '1;
  logic [1:0] i_op_stats = '1;
  logic [13:0] i_irq_psw = '1, i_rtne_ctl = '1;
  logic [26:0] i_check_bits = '1;
  logic [24:0] i_mode_rest = '1;
  logic [18:0] i_ls_ctl = '1, i_buf_data = '1;
  logic [8:0] i_large_core_option = '1;
  logic [4:0] i_io_flags = 5'h16, i_rtne_req = 5'h0b, i_chan_flags = 5'h13;
  logic [23:0] i_buf_status = '1, i_sel_status = '1;
  logic [21:0] i_iface_lines = '1;
  logic [7:0] i_sel_checks = 8'hc3, i_position_reg = 8'h96;
  logic [15:0] i_pos_rest = '1, i_rsv_sel = 16'h1357, i_rsv_mpx = 16'h2468;
  logic [6:0] i_gp_reg = '1;
  logic [17:0] i_gp_rest = '1;
  int fails = 0, comparisons = 0, n0;
  logout_image_layout u_logout_image_layout (.*);
  logout_store u_logout_store (.i_clk_sys(i_clk_sys), .i_we(o_sto_we), .i_addr(o_sto_addr),
    .i_word({o_sto_par, o_sto_data}));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fails++;
      $display("mismatch %0t %h %h", $time, seen, exp);
    end
  endtask
  // Field of a stored word, first bit counted from the high end
  task automatic cf(input logic [11:0] a, input int f, input int w, input logic [31:0] e);
    chk((u_logout_store.mem[a[11:2]] >> (32 - f - w)) & ~(32'hffff_ffff << w), e);
  endtask
  task automatic rg(input logic rd, input logic [3:0] a, input logic [31:0] v);
    @(posedge i_clk_sys);
    i_reg_rd <= rd;
    i_reg_wr <= !rd;
    i_reg_addr <= a;
    i_reg_wdata <= v;
    @(posedge i_clk_sys);
    {i_reg_rd, i_reg_wr} <= 2'b00;
    #1 d = o_reg_rdata; // Read data stand only in this cycle
  endtask
  // Starts an image, polls done under a bound, then judges order and parity
  task automatic run(input logic [31:0] ctl, input int nw, input logic [11:0] b);
    logic [35:0] w;
    n0 = u_logout_store.n;
    rg(0, R_CTRL, ctl);
    rg(0, R_CTRL, ctl ^ 32'h2); // Start while busy, other mode: must be ignored
    repeat (80)
    begin
      rg(1, R_STATUS, 0);
      if (d[S_DONE] === 1'b1) break;
    end
    chk(d[S_DONE], 1'b1);
    chk(u_logout_store.n - n0, nw);
    for (int k = 0; k < nw; k++)
    begin
      w = u_logout_store.mem[u_logout_store.log_a[n0 + k][11:2]];
      chk(u_logout_store.log_a[n0 + k], b + 4 * k);
      chk(w[35:32] ^ {^w[31:24], ^w[23:16], ^w[15:8], ^w[7:0]}, 4'hf);
    end
  endtask
  task automatic full_logout();
    logic [31:0] r [5];
    r = '{i_h, i_m, i_r, i_l, i_storage_data_reg};
    run(32'h1, 41, A_SAR);
    cf(A_MW1, 12, 7, i_microword_data_reg[12:18]);
    cf(A_MW2, 4, 9, i_microword_data_reg[35:43]);
    cf(A_MW3, 1, 4, i_microword_data_reg[57:60]);
    cf(A_MW3, 28, 4, i_microword_data_reg[84:87]);
    cf(A_MW4, 24, 2, i_microword_data_reg[88:89]);
    cf(A_OPCOPY, 6, 12, i_cur_ros_addr);
    chk(u_logout_store.mem[A_OPCOPY[11:2]], u_logout_store.mem[A_OPST[11:2]]);
    cf(A_MODE, 4, 2, {i_timer_irq, i_console_irq});
    foreach (r[k])
    begin
      cf(A_REGS + 8 * k, 0, 32, r[k]);
      cf(A_REGS + 8 * k + 4, 0, 32, {r[k][3:0], 4'h0});
    end
    cf(A_IOINST, 12, 5, i_io_flags);
    cf(A_CHRTNE, 14, 4, i_sbc_reg);
    cf(A_CHRTNE, 19, 4, {i_microword_data_reg[33:34], i_microword_data_reg[47:48]});
    cf(A_MPXCTL, 4, 14, {i_rtne_req, i_priority, i_ctl_trigs});
    cf(A_SELB, 0, 32, i_sel_b);
    cf(A_SELBP, 0, 32, i_sel_b_par);
    cf(A_SELCP, 0, 32, i_sel_c_par);
    cf(A_SELC, 0, 32, i_sel_c);
    cf(A_SELCHK, 24, 8, i_sel_checks);
    cf(A_POS, 0, 11, {i_position_reg, i_cyc_step});
    cf(A_POS, 28, 4, i_cc_detect);
    cf(A_GPREG, 9, 5, i_chan_flags);
    cf(A_RSV, 0, 32, {i_rsv_sel, i_rsv_mpx});
    cf(A_LSTORE, 20, 6, i_len_ctr1);
    cf(A_GRP4, 0, 32, i_grp4_par);
  endtask
  // Channel-only image with done cleared in the same write; unmapped read
  task automatic chan_logout();
    logic [11:0] o;
    o = A_SELB - A_CHAN_LOW;
    run(32'h7, 12, A_CHAN_LOW);
    cf(A_SELCHK - o, 24, 8, i_sel_checks);
    cf(A_RSV - o, 0, 32, {i_rsv_sel, i_rsv_mpx});
    rg(1, R_STATUS, 0);
    chk(d[S_CHAN], 1'b1);
    rg(1, 4'h8, 0);
    chk(d, 0);
  endtask
  task automatic conclude();
    if (fails == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial forever #10 i_clk_sys = ~i_clk_sys;
  // Watchdog well beyond the 70 or so cycles the two images take
  initial
  begin
    #200000;
    fails++;
    conclude();
  end
  initial
  begin
    repeat (6) @(posedge i_clk_sys);
    i_rst <= 0;
    full_logout();
    chan_logout();
    conclude();
  end
endmodule
